// ==== cid_pkg.sv ====
// package of the caller-id event logic: widths, field positions, timing
// assumes a single 100 MHz clock domain; no other files needed
package cid_pkg;

	// system clock period in picoseconds (100 MHz)
	localparam int unsigned CLK_PERIOD_PS  = 10000;
	// guard-time timebase period in nanoseconds (0.858 ms)
	localparam int unsigned GUARD_TICK_NS  = 858000;
	// cycles per guard tick, rounded down (85800), not clamped to a minimum
	localparam int unsigned GUARD_TICK_CYC =
		(GUARD_TICK_NS * 1000) / CLK_PERIOD_PS;

	// guard timer and threshold width
	localparam int unsigned GUARD_W        = 8;
	// dual-tone symbol width
	localparam int unsigned SYM_W          = 4;

	// detector flag register bit positions
	localparam int unsigned FLAG_RING      = 0;
	localparam int unsigned FLAG_ALERT     = 1;
	localparam int unsigned FLAG_DTONE     = 2;
	localparam int unsigned FLAG_FSK       = 3;
	localparam int unsigned FLAG_W         = 4;

	// reset values
	localparam logic [FLAG_W-1:0]  FLAGS_RST  = 4'h0;
	localparam logic [GUARD_W-1:0] TIMER_RST  = 8'h00;

	// enable bits from the fsk data register
	typedef struct packed {
		logic fsk_decoder_enable;
		logic alert_tone_enable;
		logic dual_tone_receiver_enable;
	} cid_enables_t;

	// raw detector inputs from the analog side
	typedef struct packed {
		logic             ring_present;
		logic             tone_raw_detect;
		logic             dual_tone_valid;
		logic [SYM_W-1:0] dual_tone_symbol;
		logic             dual_tone_band;
		logic             fsk_byte_ready;
		logic [7:0]       fsk_byte;
	} cid_detect_t;

	// guard timer phase
	typedef enum logic [1:0] {
		GT_IDLE,
		GT_PRESENT,
		GT_VALID,
		GT_ABSENT
	} cid_guard_state_t;

endpackage

// ==== cid_guard_timer.sv ====
// guard-time timer for the alert tone: turns raw detect into tone_valid
// assumes tone_raw_detect is synchronous to clk and already gated by enables
`timescale 1ns/100ps
`default_nettype none

module cid_guard_timer #(
	parameter int unsigned TICK_CYC = cid_pkg::GUARD_TICK_CYC
) (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// detector side
	input  wire logic                         tone_raw_detect,
	input  wire logic [cid_pkg::GUARD_W-1:0]  tone_present_threshold,
	input  wire logic [cid_pkg::GUARD_W-1:0]  tone_absent_threshold,
	// result
	output logic                              tone_valid,
	output logic [cid_pkg::GUARD_W-1:0]       guard_count
);

	localparam int unsigned PW = $clog2(TICK_CYC + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);

	cid_pkg::cid_guard_state_t state_ff;     // phase
	cid_pkg::cid_guard_state_t nxt_state;    // next phase
	logic [PW-1:0]             pre_ff;       // prescaler to 0.858 ms
	logic [cid_pkg::GUARD_W-1:0] cnt_ff;     // guard timer
	logic                      raw_ff;       // raw detect delayed
	logic                      valid_ff;     // tone valid bit

	// edges of the raw detect
	wire raw_rise = tone_raw_detect & ~raw_ff;
	wire raw_fall = ~tone_raw_detect & raw_ff;
	// timebase tick
	wire tick     = (pre_ff == PRE_LAST);
	// threshold matches
	wire hit_pt   = (cnt_ff == tone_present_threshold);
	wire hit_at   = (cnt_ff == tone_absent_threshold);
	// timer restarts on either raw edge
	wire restart  = raw_rise | raw_fall;
	// counting only while timing a phase and not yet matched
	wire counting = ((state_ff == cid_pkg::GT_PRESENT) & ~hit_pt) |
		((state_ff == cid_pkg::GT_ABSENT) & ~hit_at);

	// phase transitions
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			cid_pkg::GT_IDLE: begin
				if (raw_rise)
					nxt_state = cid_pkg::GT_PRESENT;
			end
			cid_pkg::GT_PRESENT: begin
				if (!tone_raw_detect)
					nxt_state = cid_pkg::GT_IDLE; // tone dropped early
				else if (hit_pt)
					nxt_state = cid_pkg::GT_VALID;
			end
			cid_pkg::GT_VALID: begin
				if (raw_fall)
					nxt_state = cid_pkg::GT_ABSENT;
			end
			cid_pkg::GT_ABSENT: begin
				if (tone_raw_detect)
					nxt_state = cid_pkg::GT_VALID; // tone back, stay valid
				else if (hit_at)
					nxt_state = cid_pkg::GT_IDLE;
			end
			default: nxt_state = cid_pkg::GT_IDLE;
		endcase
	end

	// state, edge history and valid bit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= cid_pkg::GT_IDLE;
			raw_ff   <= 1'b0;
			valid_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			raw_ff   <= tone_raw_detect;
			valid_ff <= (nxt_state == cid_pkg::GT_VALID) |
				(nxt_state == cid_pkg::GT_ABSENT);
		end
	end

	// prescaler, restarted with the timer so intervals are whole ticks
	always_ff @(posedge clk) begin
		if (!rst_n || restart || tick)
			pre_ff <= '0;
		else
			pre_ff <= pre_ff + PW'(1);
	end

	// guard timer: cleared on raw edge, counts up, holds on match
	always_ff @(posedge clk) begin
		if (!rst_n)
			cnt_ff <= cid_pkg::TIMER_RST;
		else if (restart)
			cnt_ff <= cid_pkg::TIMER_RST;
		else if (tick && counting)
			cnt_ff <= cnt_ff + 8'h01;
	end

	assign tone_valid  = valid_ff;
	assign guard_count = cnt_ff;

endmodule

`default_nettype wire

// ==== cid_event_logic.sv ====
// caller-id event logic: enables, detector flags and shared flag
// assumes detector inputs are synchronous to clk; software clears by pulse
`timescale 1ns/100ps
`default_nettype none

module cid_event_logic #(
	parameter int unsigned TICK_CYC = cid_pkg::GUARD_TICK_CYC
) (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// software control
	input  wire cid_pkg::cid_enables_t         enables,
	input  wire logic                          caller_id_global_enable,
	input  wire logic                          tone_detector_mode,
	input  wire logic [cid_pkg::GUARD_W-1:0]   tone_present_threshold,
	input  wire logic [cid_pkg::GUARD_W-1:0]   tone_absent_threshold,
	input  wire logic [cid_pkg::FLAG_W-1:0]    flag_clear,
	// detector inputs
	input  wire cid_pkg::cid_detect_t          detect,
	// enables to the analog detectors
	output logic                               fsk_run,
	output logic                               alert_run,
	output logic                               dual_tone_run,
	// status
	output logic                               tone_valid,
	output logic [cid_pkg::GUARD_W-1:0]        guard_count,
	output logic [cid_pkg::FLAG_W-1:0]         detector_flag_register,
	output logic                               shared_detector_flag,
	output logic [cid_pkg::SYM_W-1:0]          dual_tone_data,
	output logic                               dual_tone_band_hit,
	output logic [7:0]                         fsk_data_register
);

	// per-function enables under the global enable
	wire fsk_on   = enables.fsk_decoder_enable &
		caller_id_global_enable;
	wire alert_on = enables.alert_tone_enable &
		caller_id_global_enable;
	wire dt_on    = enables.dual_tone_receiver_enable &
		caller_id_global_enable;
	// dual-tone split by mode
	wire dt_dec   = dt_on & ~tone_detector_mode;
	wire dt_band  = dt_on & tone_detector_mode;

	// event sources, gated by enables except ring
	wire tone_raw = detect.tone_raw_detect & alert_on;
	wire dt_vld   = detect.dual_tone_valid & dt_dec;
	wire fsk_rdy  = detect.fsk_byte_ready & fsk_on;
	wire ring     = detect.ring_present;

	logic                        tone_valid_w;  // from guard timer
	logic [cid_pkg::FLAG_W-1:0]  src_ff;        // previous source levels
	logic [cid_pkg::FLAG_W-1:0]  src_now;       // current source levels
	logic [cid_pkg::FLAG_W-1:0]  rise;          // rising edges
	logic [cid_pkg::FLAG_W-1:0]  flags_ff;      // sticky flags
	logic [cid_pkg::SYM_W-1:0]   sym_ff;        // decoded symbol
	logic                        band_ff;       // band tone seen
	logic [7:0]                  fsk_ff;        // received byte

	// guard timer for the alert tone
	cid_guard_timer #(
		.TICK_CYC (TICK_CYC)
	) u_guard (
		.clk                    (clk),
		.rst_n                  (rst_n),
		.tone_raw_detect        (tone_raw),
		.tone_present_threshold (tone_present_threshold),
		.tone_absent_threshold  (tone_absent_threshold),
		.tone_valid             (tone_valid_w),
		.guard_count            (guard_count)
	);

	// gather flag sources by bit position
	always_comb begin
		src_now = '0;
		src_now[cid_pkg::FLAG_RING]  = ring;
		src_now[cid_pkg::FLAG_ALERT] = tone_valid_w;
		src_now[cid_pkg::FLAG_DTONE] = dt_vld;
		src_now[cid_pkg::FLAG_FSK]   = fsk_rdy;
	end

	assign rise = src_now & ~src_ff;

	// source history
	always_ff @(posedge clk) begin
		if (!rst_n)
			src_ff <= cid_pkg::FLAGS_RST;
		else
			src_ff <= src_now;
	end

	// sticky flags, one per bit; set beats clear
	genvar gi;
	generate
		for (gi = 0; gi < cid_pkg::FLAG_W; gi++) begin : g_flag
			always_ff @(posedge clk) begin
				if (!rst_n)
					flags_ff[gi] <= 1'b0;
				else if (rise[gi])
					flags_ff[gi] <= 1'b1;
				else if (flag_clear[gi])
					flags_ff[gi] <= 1'b0;
			end
		end
	endgenerate

	// captured data: symbol on valid rise, band hit, fsk byte
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sym_ff  <= 4'h0;
			band_ff <= 1'b0;
			fsk_ff  <= 8'h00;
		end else begin
			if (rise[cid_pkg::FLAG_DTONE])
				sym_ff <= detect.dual_tone_symbol;
			band_ff <= detect.dual_tone_band & dt_band;
			if (rise[cid_pkg::FLAG_FSK])
				fsk_ff <= detect.fsk_byte;
		end
	end

	// outputs
	assign fsk_run                = fsk_on;
	assign alert_run              = alert_on;
	assign dual_tone_run          = dt_on;
	assign tone_valid             = tone_valid_w;
	assign detector_flag_register = flags_ff;
	assign shared_detector_flag   = |flags_ff;
	assign dual_tone_data         = sym_ff;
	assign dual_tone_band_hit     = band_ff;
	assign fsk_data_register      = fsk_ff;

endmodule

`default_nettype wire

// ==== cid_event_logic_monitor.sv ====
// assertion checker for the caller-id event logic ports
// bound below to every cid_event_logic instance
`timescale 1ns/100ps
`default_nettype none
module cid_event_logic_monitor #(
	parameter int unsigned TICK_CYC = cid_pkg::GUARD_TICK_CYC
) (
	// clock and reset
	input wire logic                        clk,
	input wire logic                        rst_n,
	// controls and detectors
	input wire cid_pkg::cid_enables_t       enables,
	input wire logic                        caller_id_global_enable,
	input wire logic [cid_pkg::GUARD_W-1:0] tone_present_threshold,
	input wire logic [cid_pkg::GUARD_W-1:0] tone_absent_threshold,
	input wire logic [cid_pkg::FLAG_W-1:0]  flag_clear,
	input wire cid_pkg::cid_detect_t        detect,
	// outputs
	input wire logic                        fsk_run,
	input wire logic                        alert_run,
	input wire logic                        dual_tone_run,
	input wire logic                        tone_valid,
	input wire logic [cid_pkg::GUARD_W-1:0] guard_count,
	input wire logic [cid_pkg::FLAG_W-1:0]  detector_flag_register,
	input wire logic                        shared_detector_flag
);
	wire logic raw_g; // tone detect as the timer sees it
	assign raw_g = detect.tone_raw_detect & alert_run;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	run_gate_a: assert property (
		{fsk_run, alert_run, dual_tone_run} ==
		(enables & {3{caller_id_global_enable}}))
		else $error("detector run mismatch");
	ring_set_a: assert property (
		$rose(detect.ring_present) |=> detector_flag_register[0])
		else $error("ring flag not set");
	ring_clr_a: assert property (
		flag_clear[0] && !$rose(detect.ring_present)
		|=> !detector_flag_register[0])
		else $error("ring flag not cleared");
	shared_or_a: assert property (
		shared_detector_flag == |detector_flag_register)
		else $error("shared flag not the or");
	alert_set_a: assert property (
		$rose(tone_valid) |=> detector_flag_register[1])
		else $error("alert flag not set");
	alert_keep_a: assert property (
		detector_flag_register[1] && !flag_clear[1]
		|=> detector_flag_register[1])
		else $error("alert flag lost");
	alert_src_a: assert property (
		$rose(detector_flag_register[1])
		|-> $past(tone_valid) && !$past(tone_valid, 2))
		else $error("alert flag without valid rise");
	valid_pt_a: assert property (
		$rose(tone_valid)
		|-> $past(guard_count) == $past(tone_present_threshold))
		else $error("valid rose off present threshold");
	valid_at_a: assert property (
		$fell(tone_valid)
		|-> $past(guard_count) == $past(tone_absent_threshold))
		else $error("valid fell off absent threshold");
	count_hold_a: assert property (
		tone_valid && $past(tone_valid) && raw_g && $past(raw_g)
		|-> $stable(guard_count))
		else $error("timer moved after match");
	count_step_a: assert property (
		guard_count != $past(guard_count)
		|-> guard_count == 8'h00 || guard_count == $past(guard_count) + 8'h01)
		else $error("timer jumped");
	raw_rst_a: assert property (
		$rose(raw_g) |=> guard_count == 8'h00)
		else $error("timer not restarted");
endmodule
bind cid_event_logic cid_event_logic_monitor #(.TICK_CYC(TICK_CYC)) mon (
	.clk(clk), .rst_n(rst_n), .enables(enables),
	.caller_id_global_enable(caller_id_global_enable),
	.tone_present_threshold(tone_present_threshold),
	.tone_absent_threshold(tone_absent_threshold),
	.flag_clear(flag_clear), .detect(detect), .fsk_run(fsk_run),
	.alert_run(alert_run), .dual_tone_run(dual_tone_run),
	.tone_valid(tone_valid), .guard_count(guard_count),
	.detector_flag_register(detector_flag_register),
	.shared_detector_flag(shared_detector_flag));
`default_nettype wire

// ==== cid_line_model.sv ====
// line detector model: ring, tone, dual-tone and fsk outputs
// bench picks events; data lines scramble while not valid
`timescale 1ns/100ps
`default_nettype none
module cid_line_model (
	// clock
	input wire logic                clk,
	// events: ring, tone, dual-tone, band, byte
	input wire logic [4:0]          ev,
	input wire logic [3:0]          sym,
	input wire logic [7:0]          fbyte,
	// detector outputs
	output var cid_pkg::cid_detect_t detect
);
	logic [7:0] junk_ff = 8'h00; // idle data pattern
	// moves away from the sampling edge
	always_ff @(negedge clk) begin
		junk_ff <= junk_ff + 8'h5b;
	end
	// data held only while its valid is high
	always_comb begin
		detect.ring_present = ev[0];
		detect.tone_raw_detect = ev[1];
		detect.dual_tone_valid = ev[2];
		detect.dual_tone_band = ev[3];
		detect.fsk_byte_ready = ev[4];
		detect.dual_tone_symbol = ev[2] ? sym : junk_ff[3:0];
		detect.fsk_byte = ev[4] ? fbyte : junk_ff;
	end
endmodule
`default_nettype wire

// ==== caller_id_event_logic_test.sv ====
// self-checking bench of cid_event_logic with the line model
// needs cid_pkg, the monitor and cid_line_model
`timescale 1ns/100ps
`default_nettype none
module caller_id_event_logic_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	cid_pkg::cid_enables_t en = 3'h0; // detector enables
	logic glob = 1'b0;
	logic mode = 1'b0;
	logic [7:0] pt = 8'h00;
	logic [7:0] at = 8'h00;
	logic [3:0] clr = 4'h0; // flag clears
	logic [4:0] ev = 5'h00; // line events
	logic [3:0] sym = 4'h0;
	logic [7:0] fbyte = 8'h00;
	cid_pkg::cid_detect_t det;
	logic fr, ar, dr, tv, band, shared;
	logic [7:0] cnt, fdata;
	logic [3:0] flags, dtd, last = 4'h0;
	logic [3:0] exp_q[$]; // expected flag values in order
	int seed = 32'h5f63658f;
	int err_count = 0;
	int n_checks = 0;
	int k;
	logic [3:0] e; // oldest expected flags
	localparam int TICK = 2; // guard prescale used in sim
	cid_line_model line (.clk(clk), .ev(ev), .sym(sym), .fbyte(fbyte),
		.detect(det));
	cid_event_logic #(.TICK_CYC(TICK)) DUT (.clk(clk), .rst_n(rst_n),
		.enables(en), .caller_id_global_enable(glob),
		.tone_detector_mode(mode), .tone_present_threshold(pt),
		.tone_absent_threshold(at), .flag_clear(clr), .detect(det),
		.fsk_run(fr), .alert_run(ar), .dual_tone_run(dr),
		.tone_valid(tv), .guard_count(cnt),
		.detector_flag_register(flags), .shared_detector_flag(shared),
		.dual_tone_data(dtd), .dual_tone_band_hit(band),
		.fsk_data_register(fdata));
	// 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// raise one event, expect its flag, then clear it
	task automatic hit(input int i, input logic [3:0] f);
		exp_q.push_back(f);
		ev[i] = 1'b1;
		repeat (3) @(negedge clk);
		exp_q.push_back(4'h0);
		clr = f;
		@(negedge clk);
		clr = 4'h0;
		ev[i] = 1'b0;
		@(negedge clk);
	endtask
	task automatic wait_tv(input logic v);
		for (k = 0; k < 200 && tv !== v; k++) @(negedge clk);
	endtask
	// every flag change takes the oldest note
	always @(posedge clk) begin
		#1;
		if (rst_n && flags !== last) begin
			e = exp_q.size() ? exp_q.pop_front() : 4'hx;
			chk({shared, flags}, {|e, e});
		end
		last = flags;
	end
	// hang guard
	initial begin
		#200000;
		err_count++;
		stop_test;
	end
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk({tv, cnt, flags, shared}, 14'h0);
		hit(0, 4'h1);
		$display("ring test done");
		for (int i = 0; i < 16; i++) begin
			{glob, en} = i[3:0];
			#1;
			chk({fr, ar, dr}, i[2:0] & {3{i[3]}});
			@(negedge clk);
		end
		glob = 1'b0;
		ev = 5'h1e;
		repeat (20) @(negedge clk);
		chk({tv, band}, 2'h0);
		ev = 5'h00;
		glob = 1'b1;
		sym = 4'($random(seed));
		hit(2, 4'h4);
		chk(dtd, sym);
		mode = 1'b1;
		ev = 5'h0c;
		repeat (3) @(negedge clk);
		chk(band, 1'b1);
		ev = 5'h00;
		fbyte = 8'($random(seed));
		hit(4, 4'h8);
		chk(fdata, fbyte);
		$display("event test done");
		pt = 8'(($random(seed) & 3) + 2);
		at = 8'(($random(seed) & 3) + 1);
		ev = 5'h02;
		repeat (2) @(negedge clk);
		ev = 5'h00;
		repeat (12) @(negedge clk);
		chk(tv, 1'b0);
		exp_q.push_back(4'h2);
		ev = 5'h02;
		wait_tv(1'b1);
		chk(k, TICK * pt + 2);
		chk({tv, cnt}, {1'b1, pt});
		repeat (6) @(negedge clk);
		chk({cnt, flags}, {pt, 4'h2});
		ev = 5'h00;
		wait_tv(1'b0);
		chk(k, TICK * at + 2);
		chk({tv, cnt, flags}, {1'b0, at, 4'h2});
		exp_q.push_back(4'h0);
		clr = 4'h2;
		@(negedge clk);
		clr = 4'h0;
		repeat (2) @(negedge clk);
		chk(exp_q.size(), 0);
		$display("alert test done");
		stop_test;
	end
endmodule
`default_nettype wire
